// File: hw/nsq_pkg.sv
package nsq_pkg;
  // ==========================================================
  // timing, figures in ns except ERASE_MAX_US in us, counts derived from the clock
  localparam int CLK_NS       = 40;
  localparam int WHR_NS       = 120;
  localparam int ADL_NS       = 300;
  localparam int WB_NS        = 200;
  localparam int ERASE_MAX_US = 10000;
  localparam int WHR_CYC      = (WHR_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADL_CYC      = (ADL_NS + CLK_NS - 1) / CLK_NS;
  localparam int WB_CYC       = (WB_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMEOUT_CYC  = (ERASE_MAX_US * 1000) / CLK_NS;
  // ==========================================================
  // opcodes
  localparam logic [7:0] OPC_READ_MODE  = 8'h00;
  localparam logic [7:0] OPC_COL_OUT    = 8'h05;
  localparam logic [7:0] OPC_COL_OUT_GO = 8'he0;
  localparam logic [7:0] OPC_CACHE_END  = 8'h3f;
  localparam logic [7:0] OPC_PROG       = 8'h80;
  localparam logic [7:0] OPC_PROG_GO    = 8'h10;
  localparam logic [7:0] OPC_CACHE_GO   = 8'h15;
  localparam logic [7:0] OPC_COL_IN     = 8'h85;
  localparam logic [7:0] OPC_REPROG     = 8'h8b;
  localparam logic [7:0] OPC_ERASE      = 8'h60;
  localparam logic [7:0] OPC_ERASE_GO   = 8'hd0;
  localparam logic [7:0] OPC_MOVE_GO    = 8'h35;
  localparam logic [7:0] OPC_STATUS     = 8'h70;
  localparam logic [7:0] OPC_RESET      = 8'hff;
  localparam logic [31:0] OPC_OTP_SEQ   = 32'h29170419;
  // ==========================================================
  // address cycles and row layout
  localparam logic [2:0] NADDR_COL  = 3'd2;
  localparam logic [2:0] NADDR_PAGE = 3'd4;
  localparam logic [2:0] NADDR_RE   = 3'd5;
  localparam logic [2:0] AFIRST_ROW = 3'd2;
  localparam int PAGE_BITS = 6;
  localparam int BLK_BITS  = 10;
  localparam logic [2:0] NOP_MAX = 3'd4;
  // ==========================================================
  // status byte fields
  localparam int ST_PES  = 0;
  localparam int ST_PREV = 1;
  localparam int ST_ARRAY_READY_FLAG = 5;
  localparam int ST_RDY  = 6;
  // ==========================================================
  typedef enum logic [3:0] {
    NSQ_OP_CACHE_END, NSQ_OP_COL_READ, NSQ_OP_PROG, NSQ_OP_CACHE_PROG,
    NSQ_OP_RAND_IN, NSQ_OP_REPROG, NSQ_OP_ERASE, NSQ_OP_COPY_READ,
    NSQ_OP_COPY_PROG, NSQ_OP_OTP_ENTER, NSQ_OP_RESET, NSQ_OP_READ_MODE,
    NSQ_OP_POLL
  } nsq_op_t;
  typedef enum logic [3:0] {
    NSQ_IDLE, NSQ_CMD1, NSQ_ADDR, NSQ_GAP, NSQ_DIN, NSQ_DOUT, NSQ_CMD2,
    NSQ_BUSY, NSQ_SCMD, NSQ_SRD, NSQ_TAIL, NSQ_DONE
  } nsq_st_t;
endpackage

// File: hw/nsq_host.sv
`timescale 1ns/1ps
// ==========================================================
// write data buffer
module nsq_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0]   cnt_r;
  logic          push, pop;
  assign in_ready  = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
      if (pop) rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (push) mem_r[wp_r] <= in_data;
  end
endmodule

// Function
// - column read: opcode, two column cycles, confirm, then data output.
// - wait write-to-read delay after confirm; output mode holds until next command.
// - pages of a block are programmed in ascending order only.
// - at most four partial programs per page between erasures.
// - page program: setup, four addresses, data, confirm; device busy.
// - a cache program sequence stays inside one block.
// - during cache program check previous status; poll array-ready, then both bits.
// - random data input only between address cycles and final confirm.
// - wait address-to-data delay before data after random input address.
// - re-program: opcode, five addresses, optional data, confirm; device busy.
// - erase when ready: opcode, two row cycles, confirm, busy, check status.
// - read and check page data before issuing a copy-back program.
// - four-opcode sequence enters the one-time area for read and program.
// - in the one-time area only the single block's rows are used; the host refuses programs outside it but does not check copy reads.
// - no erase in the one-time area; reset leaves it.
// - after a status read the read mode opcode resumes data output.
module nsq_host #(
  parameter int FIFO_DEPTH = 4,
  parameter int LEN_W      = 12,
  parameter int TIMEOUT    = nsq_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // user command port
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  wire logic [3:0]       cmd_op,
  input  wire logic             cmd_hold,
  input  wire logic [15:0]      cmd_col,
  input  wire logic [23:0]      cmd_row,
  input  wire logic [LEN_W-1:0] cmd_len,
  output logic                  done,
  output logic                  err,
  output logic [7:0]            status,
  output logic                  otp_mode,
  // user write data
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [7:0]       wr_data,
  // user read data
  output logic                  rd_valid,
  output logic [7:0]            rd_data,
  // flash pins
  output logic                  ce_n,
  output logic                  cle,
  output logic                  ale,
  output logic                  we_n,
  output logic                  re_n,
  output logic                  wp_n,
  output logic [7:0]            io_out,
  output logic                  io_oe_n,
  input  wire logic [7:0]       io_in,
  input  wire logic             rb_n
);
  localparam int TW = $clog2(TIMEOUT + 1);
  typedef logic [TW-1:0] nsq_tmr_t;

  nsq_pkg::nsq_st_t st_r, st_nxt, gto_r, gto_nxt;
  nsq_pkg::nsq_op_t op_r, op_nxt;
  logic [15:0] col_r, col_nxt;
  logic [23:0] row_r, row_nxt, last_r, last_nxt;
  logic [LEN_W-1:0] len_r, len_nxt;
  nsq_tmr_t tmr_r, tmr_nxt;
  logic [2:0] k_r, k_nxt, nop_r, nop_nxt;
  logic ph_r, ph_nxt, hold_r, hold_nxt, open_r, open_nxt, otp_r, otp_nxt;
  logic cact_r, cact_nxt, chk_r, chk_nxt, valid_last_r, valid_last_nxt;
  logic [7:0] conf_r, conf_nxt, stat_r, stat_nxt, rdd_r, rdd_nxt, io_r, io_nxt;
  logic done_r, done_nxt, err_r, err_nxt, rdv_r, rdv_nxt;
  logic cle_r, cle_nxt, ale_r, ale_nxt, we_r, we_nxt, re_r, re_nxt, oe_r, oe_nxt;
  // decoded sequence of the current op
  logic [7:0] c1, c2;
  logic [2:0] naddr, afirst;
  logic has_c2, din, dout, bsy, chk_st, is_prog, refuse;
  logic [39:0] avec;
  logic [7:0] abyte;
  logic f_ov, f_or;
  logic [7:0] f_od;

  nsq_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .in_valid (wr_valid),
    .in_ready (wr_ready),
    .in_data  (wr_data),
    .out_valid(f_ov),
    .out_ready(f_or),
    .out_data (f_od)
  );

  // ==========================================================
  // op decode
  always_comb begin
    c1 = nsq_pkg::OPC_READ_MODE;
    c2 = nsq_pkg::OPC_PROG_GO;
    naddr = '0;
    afirst = '0;
    has_c2 = 1'b0;
    din = 1'b0;
    dout = 1'b0;
    bsy = 1'b0;
    chk_st = 1'b0;
    case (op_r)
      nsq_pkg::NSQ_OP_CACHE_END: begin
        c1 = nsq_pkg::OPC_CACHE_END;
        bsy = 1'b1;
      end
      nsq_pkg::NSQ_OP_COL_READ: begin
        c1 = nsq_pkg::OPC_COL_OUT;
        c2 = nsq_pkg::OPC_COL_OUT_GO;
        naddr = nsq_pkg::NADDR_COL;
        has_c2 = 1'b1;
        dout = 1'b1;
      end
      nsq_pkg::NSQ_OP_PROG, nsq_pkg::NSQ_OP_CACHE_PROG: begin
        c1 = nsq_pkg::OPC_PROG;
        c2 = (op_r == nsq_pkg::NSQ_OP_PROG) ? nsq_pkg::OPC_PROG_GO : nsq_pkg::OPC_CACHE_GO;
        naddr = nsq_pkg::NADDR_PAGE;
        {has_c2, din, bsy, chk_st} = {!hold_r, 3'b111};
      end
      nsq_pkg::NSQ_OP_RAND_IN: begin
        c1 = nsq_pkg::OPC_COL_IN;
        c2 = conf_r;
        naddr = nsq_pkg::NADDR_COL;
        {has_c2, din, bsy, chk_st} = {!hold_r, 3'b111};
      end
      nsq_pkg::NSQ_OP_REPROG: begin
        c1 = nsq_pkg::OPC_REPROG;
        naddr = nsq_pkg::NADDR_RE;
        {has_c2, din, bsy, chk_st} = {!hold_r, 3'b111};
      end
      nsq_pkg::NSQ_OP_COPY_PROG: begin
        c1 = nsq_pkg::OPC_COL_IN;
        naddr = nsq_pkg::NADDR_PAGE;
        {has_c2, din, bsy, chk_st} = {!hold_r, 3'b111};
      end
      nsq_pkg::NSQ_OP_ERASE: begin
        c1 = nsq_pkg::OPC_ERASE;
        c2 = nsq_pkg::OPC_ERASE_GO;
        naddr = nsq_pkg::NADDR_COL;
        afirst = nsq_pkg::AFIRST_ROW;
        {has_c2, bsy, chk_st} = 3'b111;
      end
      nsq_pkg::NSQ_OP_COPY_READ: begin
        c2 = nsq_pkg::OPC_MOVE_GO;
        naddr = nsq_pkg::NADDR_PAGE;
        {has_c2, bsy} = 2'b11;
      end
      nsq_pkg::NSQ_OP_OTP_ENTER: c1 = nsq_pkg::OPC_OTP_SEQ[31 - 8 * k_r[1:0] -: 8];
      nsq_pkg::NSQ_OP_RESET: begin
        c1 = nsq_pkg::OPC_RESET;
        bsy = 1'b1;
      end
      default: ;
    endcase
  end

  assign is_prog = (cmd_op == nsq_pkg::NSQ_OP_PROG) || (cmd_op == nsq_pkg::NSQ_OP_CACHE_PROG)
                || (cmd_op == nsq_pkg::NSQ_OP_REPROG) || (cmd_op == nsq_pkg::NSQ_OP_COPY_PROG);
  assign avec    = {cmd_row[23:0] & 24'h0, 16'h0} | {row_r, col_r};
  assign abyte   = avec[{k_r + afirst, 3'b000} +: 8];

  // ==========================================================
  // host-side legality checks on a new command
  always_comb begin
    refuse = 1'b0;
    if (open_r != (cmd_op == nsq_pkg::NSQ_OP_RAND_IN) && cmd_op != nsq_pkg::NSQ_OP_RESET)
      refuse = 1'b1;
    if (otp_r && cmd_op == nsq_pkg::NSQ_OP_ERASE) refuse = 1'b1;
    if (otp_r && is_prog && cmd_row[23:nsq_pkg::PAGE_BITS] != '0) refuse = 1'b1;
    if (is_prog && valid_last_r) begin
      if (cmd_row[23:nsq_pkg::PAGE_BITS] == last_r[23:nsq_pkg::PAGE_BITS]
          && cmd_row[nsq_pkg::PAGE_BITS-1:0] < last_r[nsq_pkg::PAGE_BITS-1:0])
        refuse = 1'b1;
      if (cmd_row == last_r && nop_r == nsq_pkg::NOP_MAX) refuse = 1'b1;
    end
    if (is_prog && cact_r && cmd_row[23:nsq_pkg::PAGE_BITS] != last_r[23:nsq_pkg::PAGE_BITS])
      refuse = 1'b1;
    if (cmd_op == nsq_pkg::NSQ_OP_COPY_PROG && !chk_r) refuse = 1'b1;
  end

  assign cmd_ready = (st_r == nsq_pkg::NSQ_IDLE) && rb_n;
  assign f_or      = (st_r == nsq_pkg::NSQ_DIN) && ph_r;

  // ==========================================================
  // sequencer
  always_comb begin
    st_nxt = st_r;
    gto_nxt = gto_r;
    op_nxt = op_r;
    {col_nxt, row_nxt, last_nxt} = {col_r, row_r, last_r};
    {len_nxt, tmr_nxt, k_nxt, nop_nxt, ph_nxt, hold_nxt} = {len_r, tmr_r, k_r, nop_r, ph_r, hold_r};
    {open_nxt, otp_nxt, cact_nxt, chk_nxt, valid_last_nxt} = {open_r, otp_r, cact_r, chk_r, valid_last_r};
    {conf_nxt, stat_nxt, rdd_nxt, io_nxt} = {conf_r, stat_r, rdd_r, io_r};
    {done_nxt, rdv_nxt} = 2'b00;
    // a failure seen in the status byte must survive the tail until done
    err_nxt = (st_r == nsq_pkg::NSQ_IDLE) ? 1'b0 : err_r;
    {cle_nxt, ale_nxt, we_nxt, re_nxt, oe_nxt} = 5'b00111;
    case (st_r)
      nsq_pkg::NSQ_IDLE: if (cmd_valid && cmd_ready) begin
        op_nxt = nsq_op_cast(cmd_op);
        {col_nxt, row_nxt, len_nxt, hold_nxt} = {cmd_col, cmd_row, cmd_len, cmd_hold};
        {k_nxt, ph_nxt} = 4'd0;
        st_nxt = (cmd_op == nsq_pkg::NSQ_OP_POLL) ? nsq_pkg::NSQ_SCMD : nsq_pkg::NSQ_CMD1;
        if (refuse) begin
          st_nxt = nsq_pkg::NSQ_DONE;
          err_nxt = 1'b1;
        end else if (is_prog) begin
          nop_nxt = (valid_last_r && cmd_row == last_r) ? nop_r + 3'd1 : 3'd1;
          {last_nxt, valid_last_nxt} = {cmd_row, 1'b1};
        end
        if (!refuse && cmd_op == nsq_pkg::NSQ_OP_COPY_READ) chk_nxt = 1'b0;
        if (!refuse && cmd_op == nsq_pkg::NSQ_OP_COL_READ) chk_nxt = 1'b1;
        if (!refuse && cmd_op == nsq_pkg::NSQ_OP_ERASE) valid_last_nxt = 1'b0;
        if (!refuse && cmd_op == nsq_pkg::NSQ_OP_RESET) otp_nxt = 1'b0;
      end
      nsq_pkg::NSQ_CMD1, nsq_pkg::NSQ_CMD2, nsq_pkg::NSQ_SCMD, nsq_pkg::NSQ_TAIL,
      nsq_pkg::NSQ_ADDR: begin
        cle_nxt = (st_r != nsq_pkg::NSQ_ADDR);
        ale_nxt = (st_r == nsq_pkg::NSQ_ADDR);
        we_nxt = ph_r;
        oe_nxt = 1'b0;
        ph_nxt = !ph_r;
        case (st_r)
          nsq_pkg::NSQ_CMD1: io_nxt = c1;
          nsq_pkg::NSQ_CMD2: io_nxt = c2;
          nsq_pkg::NSQ_SCMD: io_nxt = nsq_pkg::OPC_STATUS;
          nsq_pkg::NSQ_TAIL: io_nxt = nsq_pkg::OPC_READ_MODE;
          default: io_nxt = abyte;
        endcase
        if (ph_r) step_after_strobe();
      end
      nsq_pkg::NSQ_GAP: begin
        if (tmr_r == '0) st_nxt = gto_r;
        else tmr_nxt = tmr_r - 1'b1;
      end
      nsq_pkg::NSQ_DIN: begin
        if (len_r == '0) st_nxt = has_c2 ? nsq_pkg::NSQ_CMD2 : nsq_pkg::NSQ_DONE;
        else if (!ph_r && f_ov) begin
          {io_nxt, we_nxt, oe_nxt, ph_nxt} = {f_od, 3'b001};
        end else if (ph_r) begin
          {oe_nxt, ph_nxt, len_nxt} = {2'b00, len_r - 1'b1};
        end
        if (len_r == '0 && !has_c2) open_nxt = 1'b1;
      end
      nsq_pkg::NSQ_DOUT, nsq_pkg::NSQ_SRD: begin
        re_nxt = ph_r;
        ph_nxt = !ph_r;
        if (st_r == nsq_pkg::NSQ_DOUT && len_r == '0) st_nxt = nsq_pkg::NSQ_DONE;
        else if (ph_r && st_r == nsq_pkg::NSQ_DOUT) begin
          {rdd_nxt, rdv_nxt, len_nxt} = {io_in, 1'b1, len_r - 1'b1};
        end else if (ph_r) begin
          stat_nxt = io_in;
          if (op_r != nsq_pkg::NSQ_OP_POLL || io_in[nsq_pkg::ST_ARRAY_READY_FLAG]) begin
            st_nxt = nsq_pkg::NSQ_TAIL;
            if (op_r == nsq_pkg::NSQ_OP_POLL) begin
              err_nxt = io_in[nsq_pkg::ST_PREV] | io_in[nsq_pkg::ST_PES];
              cact_nxt = 1'b0;
            end else if (op_r == nsq_pkg::NSQ_OP_CACHE_PROG) begin
              err_nxt = io_in[nsq_pkg::ST_PREV];
            end else begin
              err_nxt = io_in[nsq_pkg::ST_PES];
            end
          end
        end
      end
      nsq_pkg::NSQ_BUSY: begin
        tmr_nxt = tmr_r - 1'b1;
        if (rb_n) begin
          st_nxt = chk_st ? nsq_pkg::NSQ_SCMD : nsq_pkg::NSQ_DONE;
          if (op_r == nsq_pkg::NSQ_OP_OTP_ENTER) otp_nxt = 1'b1;
        end else if (tmr_r == '0) begin
          st_nxt = nsq_pkg::NSQ_DONE;
          err_nxt = 1'b1;
        end
      end
      nsq_pkg::NSQ_DONE: begin
        {done_nxt, err_nxt} = {1'b1, err_r};
        st_nxt = nsq_pkg::NSQ_IDLE;
      end
      default: st_nxt = nsq_pkg::NSQ_IDLE;
    endcase
  end

  function automatic nsq_pkg::nsq_op_t nsq_op_cast(input logic [3:0] v);
    return nsq_pkg::nsq_op_t'(v);
  endfunction

  // next step once a command or address strobe has risen
  function automatic void step_after_strobe();
    case (st_r)
      nsq_pkg::NSQ_CMD1: begin
        k_nxt = k_r + 3'd1;
        if (op_r == nsq_pkg::NSQ_OP_OTP_ENTER && k_r != 3'd3) st_nxt = nsq_pkg::NSQ_CMD1;
        else if (naddr != '0) begin
          st_nxt = nsq_pkg::NSQ_ADDR;
          k_nxt = 3'd0;
        end
        else if (bsy || op_r == nsq_pkg::NSQ_OP_OTP_ENTER) go_gap(nsq_pkg::NSQ_BUSY, nsq_pkg::WB_CYC);
        else st_nxt = nsq_pkg::NSQ_DONE;
      end
      nsq_pkg::NSQ_ADDR: begin
        k_nxt = k_r + 3'd1;
        if (k_r == naddr - 3'd1) begin
          if (din) go_gap(nsq_pkg::NSQ_DIN, nsq_pkg::ADL_CYC);
          else st_nxt = nsq_pkg::NSQ_CMD2;
          if (op_r != nsq_pkg::NSQ_OP_RAND_IN) conf_nxt = c2;
        end
      end
      nsq_pkg::NSQ_CMD2: begin
        open_nxt = 1'b0;
        if (op_r == nsq_pkg::NSQ_OP_CACHE_PROG) cact_nxt = 1'b1;
        else if (din) cact_nxt = 1'b0;
        if (dout) go_gap(nsq_pkg::NSQ_DOUT, nsq_pkg::WHR_CYC);
        else go_gap(nsq_pkg::NSQ_BUSY, nsq_pkg::WB_CYC);
      end
      nsq_pkg::NSQ_SCMD: go_gap(nsq_pkg::NSQ_SRD, nsq_pkg::WHR_CYC);
      default: st_nxt = nsq_pkg::NSQ_DONE;
    endcase
  endfunction

  function automatic void go_gap(input nsq_pkg::nsq_st_t to, input int cyc);
    st_nxt = nsq_pkg::NSQ_GAP;
    gto_nxt = to;
    tmr_nxt = (to == nsq_pkg::NSQ_BUSY) ? TW'(cyc - 1) : TW'(cyc - 1);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_r <= nsq_pkg::NSQ_IDLE;
      gto_r <= nsq_pkg::NSQ_IDLE;
      op_r <= nsq_pkg::NSQ_OP_RESET;
      {col_r, row_r, last_r, len_r, tmr_r, k_r, nop_r} <= '0;
      {ph_r, hold_r, open_r, otp_r, cact_r, chk_r, valid_last_r} <= '0;
      {conf_r, stat_r, rdd_r, io_r, done_r, err_r, rdv_r} <= '0;
      {cle_r, ale_r, we_r, re_r, oe_r} <= 5'b00111;
    end else begin
      st_r <= st_nxt;
      gto_r <= gto_nxt;
      op_r <= op_nxt;
      {col_r, row_r, last_r, len_r} <= {col_nxt, row_nxt, last_nxt, len_nxt};
      {tmr_r, k_r, nop_r} <= {(st_nxt == nsq_pkg::NSQ_BUSY && st_r != nsq_pkg::NSQ_BUSY)
                             ? TW'(TIMEOUT - 1) : tmr_nxt, k_nxt, nop_nxt};
      {ph_r, hold_r, open_r, otp_r, cact_r, chk_r, valid_last_r} <=
        {ph_nxt, hold_nxt, open_nxt, otp_nxt, cact_nxt, chk_nxt, valid_last_nxt};
      {conf_r, stat_r, rdd_r, io_r, done_r, err_r, rdv_r} <=
        {conf_nxt, stat_nxt, rdd_nxt, io_nxt, done_nxt, err_nxt, rdv_nxt};
      {cle_r, ale_r, we_r, re_r, oe_r} <= {cle_nxt, ale_nxt, we_nxt, re_nxt, oe_nxt};
    end
  end

  assign {ce_n, wp_n} = 2'b01;
  assign {cle, ale, we_n, re_n, io_oe_n, io_out} = {cle_r, ale_r, we_r, re_r, oe_r, io_r};
  assign {done, status, otp_mode, rd_valid, rd_data} = {done_r, stat_r, otp_r, rdv_r, rdd_r};
  assign err = err_r & done_r;

  // ==========================================================
  // assertions
  AST_WHR_GAP: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_r == nsq_pkg::NSQ_CMD2 && ph_r && dout) |=> re_n[*3]) else $error("read too soon");
  AST_ADL_GAP: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_r == nsq_pkg::NSQ_ADDR && ph_r && din && k_r == naddr - 3'd1) |=> we_n[*8])
    else $error("data too soon");
  AST_NO_OTP_ERASE: assert property (@(posedge clk_sys) disable iff (!nrst)
    (otp_r && st_r == nsq_pkg::NSQ_CMD1) |-> op_r != nsq_pkg::NSQ_OP_ERASE)
    else $error("erase in one-time area");
  AST_READ_MODE_TAIL: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_r == nsq_pkg::NSQ_SRD && st_nxt == nsq_pkg::NSQ_TAIL) |=> ##1
    (cle && !we_n && io_out == nsq_pkg::OPC_READ_MODE)) else $error("no read mode");
  AST_NOP_LIMIT: assert property (@(posedge clk_sys) disable iff (!nrst)
    nop_r <= nsq_pkg::NOP_MAX) else $error("too many partial programs");
  AST_PAGE_ORDER: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cmd_valid && cmd_ready && is_prog && valid_last_r && !refuse
     && cmd_row[23:6] == last_r[23:6]) |-> cmd_row[5:0] >= last_r[5:0])
    else $error("page out of order");
  AST_ERASE_ADDR: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($rose(st_r == nsq_pkg::NSQ_ADDR) && op_r == nsq_pkg::NSQ_OP_ERASE) |->
    (st_r == nsq_pkg::NSQ_ADDR)[*4] ##1 st_r == nsq_pkg::NSQ_CMD2) else $error("erase address");
  AST_COL_ADDR: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($rose(st_r == nsq_pkg::NSQ_ADDR) && op_r == nsq_pkg::NSQ_OP_COL_READ) |->
    (st_r == nsq_pkg::NSQ_ADDR)[*4] ##1 st_r == nsq_pkg::NSQ_CMD2) else $error("column address");
  AST_CACHE_BLOCK: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cmd_valid && cmd_ready && is_prog && cact_r && cmd_row[23:6] != last_r[23:6]) |=> ##1 err)
    else $error("cache program left block");
  AST_RAND_IN_OPEN: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_r == nsq_pkg::NSQ_CMD1 && op_r == nsq_pkg::NSQ_OP_RAND_IN) |-> open_r)
    else $error("random input outside a program");
  CV_ERASE: cover property (@(posedge clk_sys) op_r == nsq_pkg::NSQ_OP_ERASE && done);
  CV_PROG: cover property (@(posedge clk_sys) op_r == nsq_pkg::NSQ_OP_PROG && done && !err);
  CV_READ: cover property (@(posedge clk_sys) rd_valid);
endmodule

// File: sim/nsq_dev_model.sv
`timescale 1ns/1ps
// ==========================================================
// behavioural flash die on the far side of the host pins
module nsq_dev_model #(
  parameter int BUSY_CYC = 10
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // flash pins
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic [7:0] io_out,
  output logic      [7:0] io_in,
  output logic            rb_n,
  // bench control and observation
  input  wire logic       fail,
  output logic      [7:0] go_op,
  output logic      [2:0] go_addr,
  output logic      [7:0] n_data
);
  logic       we_q, re_q, st_mode;
  logic [2:0] n_addr;
  logic [7:0] col, rd_byte;
  int         busy;
  assign rb_n    = (busy == 0);
  assign rd_byte = st_mode ? {1'b0, rb_n, rb_n, 4'h0, fail} : 8'ha0 + col;
  // released bus shows the inverse so a late sample cannot pass
  assign io_in   = re_n ? ~rd_byte : rd_byte;
  always @(posedge clk_sys) begin
    we_q <= we_n;
    re_q <= re_n;
    if (busy > 0) busy <= busy - 1;
    if (!nrst) begin
      busy <= 0;
      st_mode <= 1'b0;
      n_addr <= 3'h0;
      n_data <= 8'h00;
      go_op <= 8'h00;
      go_addr <= 3'h0;
      col <= 8'h00;
    end else if (we_n && !we_q && cle) begin
      st_mode <= (io_out == 8'h70);
      n_addr <= 3'h0;
      if (io_out == 8'h80) n_data <= 8'h00;
      if (io_out inside {8'h10, 8'h15, 8'h3f, 8'hd0, 8'he0, 8'h35}) begin
        go_op <= io_out;
        go_addr <= n_addr;
      end
      if (io_out inside {8'h10, 8'h15, 8'h3f, 8'hd0, 8'h35}) busy <= BUSY_CYC;
      if (io_out == 8'h3f) col <= 8'h00;
    end else if (we_n && !we_q && ale) begin
      if (n_addr == 3'h0) col <= io_out;
      n_addr <= n_addr + 3'h1;
    end else if (we_n && !we_q) n_data <= n_data + 8'h01;
    else if (re_n && !re_q && !st_mode) col <= col + 8'h01;
  end
endmodule

// File: sim/nsq_host_tb.sv
`timescale 1ns/1ps
module nsq_host_tb;
  logic        clk_sys, nrst, cmd_valid, cmd_ready, cmd_hold, done, err, otp_mode, fail;
  logic        wr_valid, wr_ready, rd_valid, ce_n, cle, ale, we_n, re_n, wp_n, io_oe_n, rb_n;
  logic [3:0]  cmd_op;
  logic [15:0] cmd_col;
  logic [23:0] cmd_row;
  logic [11:0] cmd_len;
  logic [7:0]  status, wr_data, rd_data, io_out, io_in, go_op, n_data;
  logic [2:0]  go_addr;
  logic [7:0]  rdq[$];
  int          errors = 0, n_compared = 0, n_fill = 0, cyc = 0;
  nsq_host #(.TIMEOUT(64)) u_nsq_host (
    .clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_hold(cmd_hold), .cmd_col(cmd_col), .cmd_row(cmd_row),
    .cmd_len(cmd_len), .done(done), .err(err), .status(status), .otp_mode(otp_mode),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .wp_n(wp_n), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in), .rb_n(rb_n));
  nsq_dev_model u_nsq_dev_model (
    .clk_sys(clk_sys), .nrst(nrst), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .io_out(io_out), .io_in(io_in), .rb_n(rb_n), .fail(fail), .go_op(go_op),
    .go_addr(go_addr), .n_data(n_data));
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
    if (wr_valid && wr_ready) n_fill <= n_fill + 1;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic close_out;
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run(input logic [3:0] op, input logic [23:0] row, input logic e);
    cmd_op = op;
    cmd_row = row;
    while (cmd_ready !== 1'b1) @(negedge clk_sys);
    cmd_valid = 1;
    @(negedge clk_sys);
    cmd_valid = 0;
    while (done !== 1'b1) @(negedge clk_sys);
    check("err", {7'h0, e}, {7'h0, err});
  endtask
  task automatic fill(input int n);
    n_fill = 0;
    wr_valid = 1;
    repeat (n) begin
      wr_data = wr_data + 8'h01;
      @(negedge clk_sys);
    end
    wr_valid = 0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_erase;
    run(nsq_pkg::NSQ_OP_ERASE, 24'h000040, 1'b0);
    check("erase go", 8'hd0, go_op);
    check("erase addr", 8'h02, {5'h0, go_addr});
    check("status", 8'h60, status & 8'h61);
  endtask
  task automatic t_prog;
    fill(6);
    check("fifo fill", 8'h04, 8'(n_fill));
    cmd_len = 12'h004;
    run(nsq_pkg::NSQ_OP_PROG, 24'h000041, 1'b0);
    check("prog go", 8'h10, go_op);
    check("prog addr", 8'h04, {5'h0, go_addr});
    check("prog data", 8'h04, n_data);
    fill(1);
    fail = 1;
    cmd_len = 12'h001;
    run(nsq_pkg::NSQ_OP_PROG, 24'h000042, 1'b1);
    fail = 0;
    run(nsq_pkg::NSQ_OP_PROG, 24'h000041, 1'b1);
    run(nsq_pkg::NSQ_OP_RAND_IN, 24'h0, 1'b1);
    fill(2);
    cmd_hold = 1;
    run(nsq_pkg::NSQ_OP_PROG, 24'h000043, 1'b0);
    cmd_hold = 0;
    run(nsq_pkg::NSQ_OP_RAND_IN, 24'h0, 1'b0);
    check("rand go", 8'h10, go_op);
    check("rand addr", 8'h02, {5'h0, go_addr});
  endtask
  task automatic t_read;
    cmd_col = 16'h0003;
    cmd_len = 12'h002;
    rdq = {};
    run(nsq_pkg::NSQ_OP_COPY_READ, 24'h000044, 1'b0);
    check("move go", 8'h35, go_op);
    run(nsq_pkg::NSQ_OP_COPY_PROG, 24'h000044, 1'b1);
    run(nsq_pkg::NSQ_OP_COL_READ, 24'h0, 1'b0);
    check("read go", 8'he0, go_op);
    check("byte0", 8'ha3, rdq[0]);
    check("byte1", 8'ha4, rdq[1]);
    cmd_len = 12'h000;
    run(nsq_pkg::NSQ_OP_COPY_PROG, 24'h000044, 1'b0);
    check("move prog addr", 8'h04, {5'h0, go_addr});
    run(nsq_pkg::NSQ_OP_CACHE_END, 24'h0, 1'b0);
    check("end go", 8'h3f, go_op);
    run(nsq_pkg::NSQ_OP_CACHE_PROG, 24'h000045, 1'b0);
    check("cache go", 8'h15, go_op);
    run(nsq_pkg::NSQ_OP_PROG, 24'h000080, 1'b1);
    run(nsq_pkg::NSQ_OP_POLL, 24'h0, 1'b0);
    check("poll status", 8'h60, status & 8'h61);
  endtask
  task automatic t_otp;
    run(nsq_pkg::NSQ_OP_OTP_ENTER, 24'h0, 1'b0);
    check("otp on", 8'h01, {7'h0, otp_mode});
    run(nsq_pkg::NSQ_OP_PROG, 24'h000080, 1'b1);
    run(nsq_pkg::NSQ_OP_ERASE, 24'h0, 1'b1);
    run(nsq_pkg::NSQ_OP_RESET, 24'h0, 1'b0);
    check("otp off", 8'h00, {7'h0, otp_mode});
  endtask
  initial begin
    {nrst, cmd_valid, cmd_hold, wr_valid, fail} = '0;
    {cmd_op, cmd_col, cmd_row, cmd_len, wr_data} = '0;
    repeat (5) @(negedge clk_sys);
    check("idle pins", 8'h27, {1'b0, ce_n, wp_n, cle, ale, we_n, re_n, io_oe_n});
    nrst = 1;
    t_erase();
    t_prog();
    t_read();
    t_otp();
    close_out();
  end
endmodule
